/* hw/ipr_pkg.sv */
// constants for the indirect pattern ram port
// Contract
// - the 512-byte pattern memory is reached only one byte at a time through the data register at offset 0x0F.
// - ownership bit 0 gives the memory to the pattern engine and 1 gives it to the host port.
// - each 0-to-1 change of the ownership bit resets the address pointer to 0x00.
// - with host ownership a write to offset 0x0F stores the byte at the pointer.
// - with host ownership the pointer advances by one at the rising write strobe that ends each write to the data port.
// - with host ownership and read-select set, a read of the data port returns the byte at the pointer.
package ipr_pkg;
  localparam int          RAM_DEPTH      = 512;
  localparam int          PTR_W          = 9;
  localparam int          DATA_W         = 8;
  localparam int          ADDR_W         = 4;
  localparam logic [3:0]  OFF_CTRL       = 4'h3;
  localparam logic [3:0]  OFF_END_FIRST  = 4'h4;
  localparam logic [3:0]  OFF_END_SECOND = 4'h5;
  localparam logic [3:0]  OFF_DATA_PORT  = 4'hF;
  localparam int          BIT_OWNER      = 3;
  localparam int          BIT_READ_SEL   = 4;
  localparam logic [7:0]  CTRL_RESET     = 8'h00;
  localparam logic [7:0]  END_RESET      = 8'h00;
  localparam logic [8:0]  PTR_RESET      = 9'h000;
endpackage

/* hw/ipr_ram.sv */
// 512 x 8 pattern memory, synchronous write, combinational read
`timescale 1ns/1ns
module ipr_ram #(
  parameter int DEPTH  = 512,
  parameter int AW     = 9,
  parameter int DW     = 8
) (
  input  wire logic          clock_in,
  input  wire logic          we_in,
  input  wire logic [AW-1:0] addr_in,
  input  wire logic [DW-1:0] wdata_in,
  output logic      [DW-1:0] rdata_out
);
  logic [DW-1:0] mem [DEPTH];

  // no reset on purpose: contents are undefined until loaded
  always_ff @(posedge clock_in) begin
    if (we_in) begin
      mem[addr_in] <= wdata_in;
    end
  end

  assign rdata_out = mem[addr_in];
endmodule

/* hw/ipr_port.sv */
// host parallel port, control bits, pointer and ram ownership mux
`timescale 1ns/1ns
module ipr_port #(
  parameter int DEPTH = ipr_pkg::RAM_DEPTH
) (
  input  wire logic                       clock_in,
  input  wire logic                       rst_in,
  input  wire logic                       cs_n_in,
  input  wire logic                       rd_n_in,
  input  wire logic                       wr_n_in,
  input  wire logic [ipr_pkg::ADDR_W-1:0] addr_in,
  input  wire logic [ipr_pkg::DATA_W-1:0] data_in,
  output logic      [ipr_pkg::DATA_W-1:0] data_out,
  output logic                            data_oe_n_out,
  input  wire logic [ipr_pkg::PTR_W-1:0]  engine_addr_in,
  output logic      [ipr_pkg::DATA_W-1:0] engine_data_out,
  output logic      [ipr_pkg::PTR_W-1:0]  pattern_end_out,
  output logic                            ram_owner_select_out
);
  localparam int PW = ipr_pkg::PTR_W;
  localparam int DW = ipr_pkg::DATA_W;

  // strobe and bus values held from the previous cycle; the strobe's
  // rising edge is seen one cycle late, with address and data still valid
  logic          wr_n_prev;
  logic          rd_n_prev;
  logic          cs_n_prev;
  logic [3:0]    addr_prev;
  logic [DW-1:0] data_prev;
  logic          wr_end;
  logic          rd_end;
  logic [7:0]    ctrl_reg;
  logic [7:0]    ctrl_next;
  logic [7:0]    end_first_reg;
  logic [7:0]    end_second_reg;
  logic [PW-1:0] ptr_reg;
  logic          owner_reg;
  logic          read_sel;
  logic          ram_we;
  logic [PW-1:0] ram_addr;
  logic [DW-1:0] ram_rdata;
  logic [DW-1:0] read_mux;
  logic          ram_loaded_reg;

  function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
    return a == off;
  endfunction

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      wr_n_prev <= 1'b1;
      rd_n_prev <= 1'b1;
      cs_n_prev <= 1'b1;
      addr_prev <= 4'h0;
      data_prev <= 8'h00;
    end else begin
      wr_n_prev <= wr_n_in;
      rd_n_prev <= rd_n_in;
      cs_n_prev <= cs_n_in;
      addr_prev <= addr_in;
      data_prev <= data_in;
    end
  end

  assign wr_end = wr_n_in && !wr_n_prev && !cs_n_prev;
  assign rd_end = rd_n_in && !rd_n_prev && !cs_n_prev;

  assign owner_reg = ctrl_reg[ipr_pkg::BIT_OWNER];
  assign read_sel  = ctrl_reg[ipr_pkg::BIT_READ_SEL];

  always_comb begin
    ctrl_next = ctrl_reg;
    if (wr_end && hit(addr_prev, ipr_pkg::OFF_CTRL)) begin
      ctrl_next = data_prev;
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      ctrl_reg <= ipr_pkg::CTRL_RESET;
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      end_first_reg  <= ipr_pkg::END_RESET;
      end_second_reg <= ipr_pkg::END_RESET;
    end else if (wr_end) begin
      if (hit(addr_prev, ipr_pkg::OFF_END_FIRST)) begin
        end_first_reg <= data_prev;
      end
      if (hit(addr_prev, ipr_pkg::OFF_END_SECOND)) begin
        end_second_reg <= data_prev;
      end
    end
  end

  // end index: low byte first, bit 8 from the low bit of the second
  assign pattern_end_out      = {end_second_reg[0], end_first_reg};
  assign ram_owner_select_out = owner_reg;

  // pointer: a rising owner bit wins over any advance in the same cycle
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      ptr_reg <= ipr_pkg::PTR_RESET;
    end else if (ctrl_next[ipr_pkg::BIT_OWNER] && !owner_reg) begin
      ptr_reg <= ipr_pkg::PTR_RESET;
    end else if (owner_reg && hit(addr_prev, ipr_pkg::OFF_DATA_PORT)
                 && (wr_end || (rd_end && read_sel))) begin
      ptr_reg <= ptr_reg + 1'b1;
    end
  end

  // writes land only through the data port while the host owns the ram
  assign ram_we   = wr_end && owner_reg
                    && hit(addr_prev, ipr_pkg::OFF_DATA_PORT);

  // ram bytes stay unknown until the host's first load; engine data
  // can only be compared once something has been written
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      ram_loaded_reg <= 1'b0;
    end else if (ram_we) begin
      ram_loaded_reg <= 1'b1;
    end
  end
  assign ram_addr = owner_reg ? ptr_reg : engine_addr_in;

  ipr_ram #(
    .DEPTH (DEPTH),
    .AW    (PW),
    .DW    (DW)
  ) u_ram (
    .clock_in  (clock_in),
    .we_in     (ram_we),
    .addr_in   (ram_addr),
    .wdata_in  (data_prev),
    .rdata_out (ram_rdata)
  );

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      engine_data_out <= 8'h00;
    end else if (!owner_reg) begin
      engine_data_out <= ram_rdata;
    end
  end

  always_comb begin
    read_mux = 8'h00;
    case (addr_in)
      ipr_pkg::OFF_CTRL:       read_mux = ctrl_reg;
      ipr_pkg::OFF_END_FIRST:  read_mux = end_first_reg;
      ipr_pkg::OFF_END_SECOND: read_mux = end_second_reg;
      ipr_pkg::OFF_DATA_PORT: begin
        // ram is readable only in host verify mode
        if (owner_reg && read_sel) begin
          read_mux = ram_rdata;
        end
      end
      default:                 read_mux = 8'h00;
    endcase
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      data_out <= 8'h00;
    end else begin
      data_out <= read_mux;
    end
  end

  // bus is driven one cycle after cs and rd go low, released with them
  assign data_oe_n_out = cs_n_in || rd_n_in || cs_n_prev || rd_n_prev;

  sequence host_read_s;
    !cs_n_in && !rd_n_in && owner_reg && read_sel
      && hit(addr_in, ipr_pkg::OFF_DATA_PORT);
  endsequence

  sequence data_write_end_s;
    wr_end && owner_reg && hit(addr_prev, ipr_pkg::OFF_DATA_PORT);
  endsequence

  ptr_reset_a: assert property (
    @(posedge clock_in) disable iff (rst_in)
    $rose(owner_reg) |-> ptr_reg == 9'h000)
    else $error("pointer not cleared on ownership rise");

  ram_write_a: assert property (
    @(posedge clock_in) disable iff (rst_in)
    data_write_end_s |-> ram_we && ram_addr == ptr_reg
      && $past(data_in) == data_prev)
    else $error("data port write not stored at pointer");

  write_advance_a: assert property (
    @(posedge clock_in) disable iff (rst_in)
    data_write_end_s ##0 !ctrl_next[ipr_pkg::BIT_OWNER] == 1'b0
      |=> ptr_reg == $past(ptr_reg) + 9'h001)
    else $error("pointer did not advance after write");

  read_advance_a: assert property (
    @(posedge clock_in) disable iff (rst_in)
    rd_end && owner_reg && read_sel
      && hit(addr_prev, ipr_pkg::OFF_DATA_PORT)
      |=> ptr_reg == $past(ptr_reg) + 9'h001)
    else $error("pointer did not advance after read");

  read_data_a: assert property (
    @(posedge clock_in) disable iff (rst_in)
    host_read_s ##1 host_read_s |-> !data_oe_n_out
      && data_out == $past(ram_rdata))
    else $error("data port read returned wrong byte");

  engine_owner_a: assert property (
    @(posedge clock_in) disable iff (rst_in)
    !owner_reg |-> !ram_we && ram_addr == engine_addr_in
      ##1 (owner_reg || !ram_loaded_reg
           || engine_data_out == $past(ram_rdata)))
    else $error("engine does not own ram while bit is 0");

  indirect_only_a: assert property (
    @(posedge clock_in) disable iff (rst_in)
    ram_we |-> $past(addr_in) == ipr_pkg::OFF_DATA_PORT
      && $past(!cs_n_in) && $past(!wr_n_in))
    else $error("ram written outside the data port");
endmodule

/* verif/ipr_host.sv */
// host processor model on the parallel control port
`timescale 1ns/1ns
module ipr_host (
  input  wire logic       clock_in,
  input  wire logic [7:0] rdata_in,
  input  wire logic       rdata_oe_n_in,
  output logic            cs_n_out,
  output logic            rd_n_out,
  output logic            wr_n_out,
  output logic      [3:0] addr_out,
  output logic      [7:0] wdata_out
);
  initial begin
    cs_n_out  = 1'b1;
    rd_n_out  = 1'b1;
    wr_n_out  = 1'b1;
    addr_out  = 4'h0;
    wdata_out = 8'h00;
  end
  // strobe low two cycles; select and address outlive the strobe
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock_in);
    cs_n_out  <= 1'b0;
    wr_n_out  <= 1'b0;
    addr_out  <= a;
    wdata_out <= d;
    repeat (2) @(posedge clock_in);
    wr_n_out <= 1'b1;
    @(posedge clock_in);
    cs_n_out  <= 1'b1;
    // a released bus must not keep showing the old byte
    wdata_out <= ~d;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] q,
                    output logic oe_n);
    @(posedge clock_in);
    cs_n_out <= 1'b0;
    rd_n_out <= 1'b0;
    addr_out <= a;
    @(posedge clock_in);
    @(negedge clock_in);
    q    = rdata_in;
    oe_n = rdata_oe_n_in;
    @(posedge clock_in);
    rd_n_out <= 1'b1;
    @(posedge clock_in);
    cs_n_out <= 1'b1;
  endtask
endmodule

/* verif/indirect_pattern_ram_port_test.sv */
// self-checking bench for the indirect pattern ram port
`timescale 1ns/1ns
module indirect_pattern_ram_port_test;
  logic       clock_in;
  logic       rst_in;
  logic       cs_n, rd_n, wr_n, oe_n, q_oe, owner;
  logic [3:0] addr;
  logic [7:0] wdata, rdata, q, x, eng_data;
  logic [8:0] eng_addr, end_idx, a;
  logic [7:0] mem [512];
  integer     seed, fail_count, num_checks, i;
  ipr_port u_dut (.clock_in(clock_in), .rst_in(rst_in), .cs_n_in(cs_n),
    .rd_n_in(rd_n), .wr_n_in(wr_n), .addr_in(addr), .data_in(wdata),
    .data_out(rdata), .data_oe_n_out(oe_n), .engine_addr_in(eng_addr),
    .engine_data_out(eng_data), .pattern_end_out(end_idx),
    .ram_owner_select_out(owner));
  ipr_host u_host (.clock_in(clock_in), .rdata_in(rdata),
    .rdata_oe_n_in(oe_n), .cs_n_out(cs_n), .rd_n_out(rd_n),
    .wr_n_out(wr_n), .addr_out(addr), .wdata_out(wdata));
  function automatic logic [8:0] end_of(input logic [7:0] lo,
                                        input logic [7:0] hi);
    return {hi[0], lo};
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("checks=%0d mismatches=%0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    clock_in = 1'b0;
    forever #20 clock_in = ~clock_in;
  end
  initial begin
    repeat (100000) @(posedge clock_in);
    fail_count++;
    conclude();
  end
  initial begin
    seed = 68707;
    fail_count = 0;
    num_checks = 0;
    rst_in = 1'b1;
    eng_addr = 9'h000;
    repeat (4) @(posedge clock_in);
    rst_in <= 1'b0;
    u_host.rd(4'h3, q, q_oe);
    check(16'({owner, q}), 16'h0000);
    check(16'(end_idx), 16'h0000);
    $display("test reset done");
    u_host.wr(4'h3, 8'h08); // owner set, read select clear
    @(negedge clock_in);
    check(16'(owner), 16'h0001);
    for (i = 0; i < 512; i++) begin
      mem[i] = 8'($random(seed));
      u_host.wr(4'hF, mem[i]);
    end
    // pointer wraps, so this lands on location zero
    x = 8'($random(seed));
    u_host.wr(4'hF, x);
    mem[0] = x;
    u_host.rd(4'hF, q, q_oe);
    check(16'(q), 16'h0000);
    u_host.wr(4'h3, 8'h00);
    u_host.wr(4'hF, ~mem[0]);
    u_host.wr(4'h3, 8'h18);
    for (i = 0; i < 514; i++) begin
      u_host.rd(4'hF, q, q_oe);
      check(16'({q_oe, q}), 16'({1'b0, mem[i % 512]}));
    end
    u_host.wr(4'h3, 8'h10);
    u_host.wr(4'h3, 8'h18);
    u_host.rd(4'hF, q, q_oe);
    check(16'(q), 16'(mem[0]));
    u_host.rd(4'h1, q, q_oe);
    check(16'(q), 16'h0000);
    $display("test load and verify done");
    u_host.wr(4'h3, 8'h00);
    @(negedge clock_in);
    check(16'(owner), 16'h0000);
    u_host.wr(4'h4, 8'hFF);
    u_host.wr(4'h5, 8'h01);
    @(negedge clock_in);
    check(16'(end_idx), 16'(end_of(8'hFF, 8'h01)));
    u_host.rd(4'h5, q, q_oe);
    check(16'(q), 16'h0001);
    for (i = 0; i < 10; i++) begin
      a = (i == 0) ? 9'h000 : (i == 1) ? 9'h1FF : 9'($random(seed));
      @(posedge clock_in);
      eng_addr <= a;
      repeat (2) @(posedge clock_in);
      @(negedge clock_in);
      check(16'(eng_data), 16'(mem[a]));
    end
    $display("test engine access done");
    conclude();
  end
endmodule
